// file: logic/ect_filter.sv
// five-stage majority-free noise filter for the capture input
`timescale 1ns/1ps
`default_nettype none
`include "ect_defines.svh"

module ect_filter
  import ect_pkg::*;
#(
  parameter int STAGES = `ECT_FILTER_STAGES
) (
  input  wire logic clk_i,     // system clock
  input  wire logic rst_i,     // synchronous reset, active high
  input  wire logic run_i,     // block not in standby
  input  wire logic sample_i,  // sampling clock enable
  input  wire logic pin_i,     // synchronised capture pin
  output logic      level_o    // filtered level
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [STAGES-1:0] taps;   // latch chain
    logic              level;  // filter output
    logic              ready;  // output initialised
  } ect_filter_state_t;

  ect_filter_state_t s_reg;    // registered state
  ect_filter_state_t s_next;   // next state

  // shift on each sample, update only on full agreement
  always_comb begin
    s_next = s_reg;
    if (run_i && sample_i) begin
      s_next.taps = {s_reg.taps[STAGES-2:0], pin_i};
    end
    // all latches low: output low, and the filter counts as initialised
    if (s_reg.taps == '0) begin
      s_next.level = 1'b0;
      s_next.ready = 1'b1;
    end else if (s_reg.taps == '1 && s_reg.ready) begin
      s_next.level = 1'b1;
    end
  end

  // register the state; taps start high so five low samples are needed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '{taps: '1, level: 1'b0, ready: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign level_o = s_reg.level;

endmodule : ect_filter
`default_nettype wire

// file: logic/ect_timer.sv
// 8-bit edge capture timer with noise filter, overflow level flags and wishbone registers
//
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ect_defines.svh"

module ect_timer
  import ect_pkg::*;
(
  input  wire logic        clk_i,        // system clock, 50 MHz
  input  wire logic        rst_i,        // synchronous reset, active high
  input  wire logic        wb_cyc_i,     // wishbone cycle
  input  wire logic        wb_stb_i,     // wishbone strobe
  input  wire logic        wb_we_i,      // wishbone write enable
  input  wire logic [7:0]  wb_adr_i,     // wishbone byte address
  input  wire logic [3:0]  wb_sel_i,     // wishbone byte lanes
  input  wire logic [31:0] wb_dat_i,     // wishbone write data
  output logic [31:0]      wb_dat_o,     // wishbone read data
  output logic             wb_ack_o,     // wishbone acknowledge
  input  wire logic        cap_pin_i,    // capture input pin
  input  wire logic        watch_clk_i,  // watch clock pin
  output logic             irq_o         // interrupt, level high
);

  // ****************************************
  // state of the block
  // ****************************************
  typedef struct packed {
    ect_control_t   ctrl;        // timer_control
    logic [7:0]     count;       // up_counter
    logic [7:0]     fall_cap;    // fall_capture_value
    logic [7:0]     rise_cap;    // rise_capture_value
    logic [7:0]     clock_stop;  // module_clock_stop
    ect_port_mode_t port_mode;   // pin function and filter select
    logic           irq_req;     // timer_irq_request
    logic           irq_en;      // timer_irq_enable
    logic [1:0]     armed;       // flags read as one, high then low
    logic           cap_d;       // previous capture signal
    logic [5:0]     pre;         // system clock prescaler
    logic [1:0]     wdiv;        // watch clock divider
    logic           pin_s0;      // pin sync first stage
    logic           pin_s1;      // pin sync second stage
    logic           wclk_s0;     // watch sync first stage
    logic           wclk_s1;     // watch sync second stage
    logic           wclk_d;      // watch edge detect stage
    logic           ack;         // bus acknowledge
    logic [31:0]    dat;         // bus read data
    logic           irq;         // interrupt output
  } ect_state_t;

  ect_state_t s_reg;   // registered state
  ect_state_t s_next;  // next state

  // ****************************************
  // combinational helpers
  // ****************************************
  logic       run;         // block out of standby
  logic       tick;        // count clock enable
  logic       watch_rise;  // rising edge of watch clock
  logic       filt_level;  // filter output
  logic       sample;      // filter sampling enable
  logic       cap_sig;     // capture signal after pin function
  logic       rise;        // rising capture edge
  logic       fall;        // falling capture edge
  logic       clr;         // counter clear this cycle
  logic       ovf;         // counter rollover this cycle
  logic       acc;         // bus access accepted
  logic       wr;          // register write
  logic       rd;          // register read
  logic [7:0] waddr;       // word aligned address
  logic [7:0] wbyte;       // write data low lane
  logic [31:0] rdata;      // read data mux

  // ****************************************
  // count clock selection
  // ****************************************
  // enable pulses from the prescaler and the watch divider
  always_comb begin
    run        = s_reg.clock_stop[`ECT_BIT_STANDBY];
    watch_rise = s_reg.wclk_s1 & ~s_reg.wclk_d;
    unique case (s_reg.ctrl.clock_select)
      ECT_CKS_DIV64: begin
        tick = (s_reg.pre == 6'(`ECT_DIV_SLOW - 7'd1));
      end
      ECT_CKS_DIV32: begin
        tick = (s_reg.pre[4:0] == 5'(`ECT_DIV_MID - 7'd1));
      end
      ECT_CKS_DIV2: begin
        tick = (s_reg.pre[0] == 1'(`ECT_DIV_FAST - 7'd1));
      end
      ECT_CKS_WATCH: begin
        tick = watch_rise && (s_reg.wdiv == 2'(`ECT_DIV_WATCH - 3'd1));
      end
    endcase
  end

  // ****************************************
  // noise filter
  // ****************************************
  // system clock when filter is off, count clock when on
  assign sample = s_reg.port_mode.filter_select ? tick : 1'b1;

  ect_filter #(
    .STAGES (`ECT_FILTER_STAGES)
  ) u_filter (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .run_i    (run),
    .sample_i (sample),
    .pin_i    (s_reg.pin_s1),
    .level_o  (filt_level)
  );

  // ****************************************
  // edge detection and counter control
  // ****************************************
  // interval mode forces the signal low, so no edges and only low overflows
  always_comb begin
    cap_sig = filt_level & s_reg.port_mode.capture_pin_function;
    rise    = run & cap_sig & ~s_reg.cap_d;
    fall    = run & ~cap_sig & s_reg.cap_d;
    clr     = (rise & s_reg.ctrl.clear_select[1]) |
              (fall & s_reg.ctrl.clear_select[0]);
    ovf     = run & tick & ~clr & (s_reg.count == `ECT_COUNT_MAX);
  end

  // ****************************************
  // bus decode
  // ****************************************
  // one cycle after the request, ack rises; unmapped reads return zero
  always_comb begin
    acc   = wb_cyc_i & wb_stb_i & ~s_reg.ack;
    wr    = acc & wb_we_i & wb_sel_i[0];
    rd    = acc & ~wb_we_i;
    waddr = {wb_adr_i[7:2], 2'b00};
    wbyte = wb_dat_i[7:0];
    rdata = 32'h0000_0000;
    unique case (waddr)
      `ECT_OFF_CONTROL: begin
        rdata[7:0] = s_reg.ctrl;
      end
      `ECT_OFF_FALL_CAP: begin
        rdata[7:0] = s_reg.fall_cap;
      end
      `ECT_OFF_RISE_CAP: begin
        rdata[7:0] = s_reg.rise_cap;
      end
      `ECT_OFF_CLOCK_STOP: begin
        rdata[7:0] = s_reg.clock_stop;
      end
      `ECT_OFF_PORT_MODE: begin
        rdata[1:0] = s_reg.port_mode;
      end
      `ECT_OFF_IRQ_STATUS: begin
        rdata[`ECT_BIT_IRQ_REQ] = s_reg.irq_req;
      end
      `ECT_OFF_IRQ_MASK: begin
        rdata[`ECT_BIT_IRQ_REQ] = s_reg.irq_en;
      end
      default: begin
        rdata = 32'h0000_0000;  // unmapped address
      end
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_next = s_reg;

    // two flip-flop synchronisers and watch clock edge stage
    s_next.pin_s0  = cap_pin_i;
    s_next.pin_s1  = s_reg.pin_s0;
    s_next.wclk_s0 = watch_clk_i;
    s_next.wclk_s1 = s_reg.wclk_s0;
    s_next.wclk_d  = s_reg.wclk_s1;

    // dividers stop in standby
    if (run) begin
      s_next.pre   = s_reg.pre + 6'h01;
      s_next.cap_d = cap_sig;
      if (watch_rise) begin
        s_next.wdiv = s_reg.wdiv + 2'h1;
      end
    end

    // counter: clear by edge wins over increment
    if (clr) begin
      s_next.count = `ECT_RST_COUNT;
    end else if (run && tick) begin
      s_next.count = s_reg.count + 8'h01;
    end

    // captures take the count before this cycle's clear
    if (rise) begin
      s_next.rise_cap = s_reg.count;
    end
    if (fall) begin
      s_next.fall_cap = s_reg.count;
    end

    // software writes
    if (wr) begin
      unique case (waddr)
        `ECT_OFF_CONTROL: begin
          // flags: a one written is ignored, a zero clears only if armed
          s_next.ctrl = ect_control_t'({s_reg.ctrl[7:6], wbyte[5:0]});
          if (!wbyte[`ECT_BIT_OVF_HIGH] && s_reg.armed[1]) begin
            s_next.ctrl.overflow_high_flag = 1'b0;
          end
          if (!wbyte[`ECT_BIT_OVF_LOW] && s_reg.armed[0]) begin
            s_next.ctrl.overflow_low_flag = 1'b0;
          end
        end
        `ECT_OFF_CLOCK_STOP: begin
          s_next.clock_stop = wbyte;
        end
        `ECT_OFF_PORT_MODE: begin
          s_next.port_mode = ect_port_mode_t'(wbyte[1:0]);
        end
        `ECT_OFF_IRQ_STATUS: begin
          if (wbyte[`ECT_BIT_IRQ_REQ]) begin
            s_next.irq_req = 1'b0;  // write one to clear
          end
        end
        `ECT_OFF_IRQ_MASK: begin
          s_next.irq_en = wbyte[`ECT_BIT_IRQ_REQ];
        end
        default: begin
          s_next.irq_en = s_reg.irq_en;  // read only or unmapped
        end
      endcase
    end

    // reading the control register arms the flags seen as one
    if (rd && waddr == `ECT_OFF_CONTROL) begin
      s_next.armed = {s_reg.ctrl.overflow_high_flag, s_reg.ctrl.overflow_low_flag};
    end

    // overflow flags by capture signal level; hardware set wins over clear
    if (ovf && cap_sig) begin
      s_next.ctrl.overflow_high_flag = 1'b1;
    end
    if (ovf && !cap_sig) begin
      s_next.ctrl.overflow_low_flag = 1'b1;
    end
    s_next.armed = s_next.armed &
                   {s_next.ctrl.overflow_high_flag, s_next.ctrl.overflow_low_flag};

    // interrupt request: selected edge, or overflow when enabled
    if ((rise && !s_reg.ctrl.irq_edge_select) ||
        (fall && s_reg.ctrl.irq_edge_select)) begin
      s_next.irq_req = 1'b1;
    end
    if (ovf && s_reg.ctrl.overflow_irq_enable) begin
      s_next.irq_req = 1'b1;
    end

    // interrupt output gated by the enable
    s_next.irq = s_next.irq_req & s_next.irq_en;

    // bus answer
    s_next.ack = acc;
    if (acc) begin
      s_next.dat = rdata;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg            <= '0;
      s_reg.ctrl       <= ect_control_t'(`ECT_RST_CONTROL);
      s_reg.count      <= `ECT_RST_COUNT;
      s_reg.fall_cap   <= `ECT_RST_CAPTURE;
      s_reg.rise_cap   <= `ECT_RST_CAPTURE;
      s_reg.clock_stop <= `ECT_RST_CLOCK_STOP;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // outputs, all from flip-flops
  // ****************************************
  assign wb_ack_o = s_reg.ack;
  assign wb_dat_o = s_reg.dat;
  assign irq_o    = s_reg.irq;

endmodule : ect_timer
`default_nettype wire

// file: shared/ect_defines.svh
// constants of the edge capture timer: offsets, bit positions, reset values, divide ratios
`ifndef ECT_DEFINES_SVH
`define ECT_DEFINES_SVH

// ****************************************
// register byte offsets
// ****************************************
`define ECT_OFF_CONTROL    8'h00
`define ECT_OFF_FALL_CAP   8'h04
`define ECT_OFF_RISE_CAP   8'h08
`define ECT_OFF_CLOCK_STOP 8'h0C
`define ECT_OFF_PORT_MODE  8'h10
`define ECT_OFF_IRQ_STATUS 8'h14
`define ECT_OFF_IRQ_MASK   8'h18

// ****************************************
// field positions
// ****************************************
`define ECT_BIT_OVF_HIGH   7
`define ECT_BIT_OVF_LOW    6
`define ECT_BIT_STANDBY    3
`define ECT_BIT_PIN_FUNC   0
`define ECT_BIT_FILTER_SEL 1
`define ECT_BIT_IRQ_REQ    0

// ****************************************
// reset values and counter maximum
// ****************************************
`define ECT_RST_CONTROL    8'h00
`define ECT_RST_COUNT      8'h00
`define ECT_RST_CAPTURE    8'h00
`define ECT_RST_CLOCK_STOP 8'hFF
`define ECT_COUNT_MAX      8'hFF

// ****************************************
// count clock divide ratios and filter stages
// ****************************************
`define ECT_DIV_SLOW       7'd64
`define ECT_DIV_MID        7'd32
`define ECT_DIV_FAST       7'd2
`define ECT_DIV_WATCH      3'd4
`define ECT_FILTER_STAGES  5

`endif

// file: shared/ect_pkg.sv
// types shared by the edge capture timer design files
package ect_pkg;

  // count clock sources selected by the clock select field
  typedef enum logic [1:0] {
    ECT_CKS_DIV64 = 2'b00,
    ECT_CKS_DIV32 = 2'b01,
    ECT_CKS_DIV2  = 2'b10,
    ECT_CKS_WATCH = 2'b11
  } ect_cks_t;

  // layout of the timer_control register
  typedef struct packed {
    logic       overflow_high_flag;
    logic       overflow_low_flag;
    logic       overflow_irq_enable;
    logic       irq_edge_select;
    logic [1:0] clear_select;
    ect_cks_t   clock_select;
  } ect_control_t;

  // port mode bits for the capture pin
  typedef struct packed {
    logic filter_select;
    logic capture_pin_function;
  } ect_port_mode_t;

endpackage : ect_pkg

// file: testbench/ect_pulse_src.sv
// external pulse source model driving the capture pin
`timescale 1ns/1ps
`default_nettype none
module ect_pulse_src (
  input  wire logic        clk_i,    // system clock
  input  wire logic        rst_i,    // synchronous reset
  input  wire logic        go_i,     // start one high pulse
  input  wire logic [15:0] width_i,  // pulse width in clocks
  input  wire logic        hold_i,   // keep the pin high
  output logic             pin_o     // capture pin level
);
  logic [15:0] left_reg;  // clocks of pulse still to go
  // pulse timer: each pulse lasts the width asked of it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      left_reg <= 16'h0000;
    end else if (go_i) begin
      left_reg <= width_i;
    end else if (left_reg != 16'h0000) begin
      left_reg <= left_reg - 16'h0001;
    end
  end
  assign pin_o = hold_i | (left_reg != 16'h0000);
endmodule // ect_pulse_src
`default_nettype wire

// file: testbench/ect_timer_sva.sv
// port assertions for the edge capture timer
`timescale 1ns/1ps
`default_nettype none
module ect_timer_sva
  import ect_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        cap_pin_i,
  input wire logic        watch_clk_i,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic mask_reg;  // shadow of the interrupt mask bit
  // shadow follows each taken write to the mask register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_reg <= 1'b0;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == 6'h06) begin
      mask_reg <= wb_dat_i[0];
    end
  end
  // a request waiting for its answer
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // a read answer for one register slot
  sequence rd_ack_s(logic [5:0] w);
    wb_ack_o && !wb_we_i && wb_adr_i[7:2] == w;
  endsequence
  ack_after_req_a: assert property (req_s |=> wb_ack_o)
    else $error("request not answered in one cycle");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("acknowledge without request");
  dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  reset_quiet_a: assert property ($fell(rst_i) |-> !wb_ack_o && !irq_o && wb_dat_o == 32'h0000_0000)
    else $error("outputs not quiet after reset");
  unmapped_zero_a: assert property (rd_ack_s(6'h07) |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  status_width_a: assert property (rd_ack_s(6'h05) |-> wb_dat_o[31:1] == 31'h0000_0000)
    else $error("status read has extra bits");
  irq_mask_a: assert property (!mask_reg && $past(!mask_reg) |-> !irq_o)
    else $error("interrupt raised while masked");
endmodule // ect_timer_sva
`default_nettype wire

// file: testbench/tb.sv
// self-checking bench for the edge capture timer
`timescale 1ns/1ps
`default_nettype none
`include "ect_defines.svh"
module tb
  import ect_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h0000_0000;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic        cap_pin;
  logic        irq;
  logic        go = 1'b0;     // pulse start to the source
  logic        hold = 1'b0;   // source keeps pin high
  logic [15:0] width = 16'h0000;
  logic [3:0]  wdiv = 4'h0;   // slow watch clock divider
  logic [31:0] rdv;           // last read word
  logic [31:0] seed = 32'h2f65_175c;
  int          n_errors = 0;
  int          checks_done = 0;
  logic [7:0]  ra [5] = '{`ECT_OFF_CONTROL, `ECT_OFF_FALL_CAP, `ECT_OFF_RISE_CAP, `ECT_OFF_CLOCK_STOP, 8'h1C};
  logic [7:0]  rv [5] = '{`ECT_RST_CONTROL, `ECT_RST_CAPTURE, `ECT_RST_CAPTURE, `ECT_RST_CLOCK_STOP, 8'h00};
  logic [7:0]  cs [4] = '{8'hF7, 8'hFF, 8'hFF, 8'hFF};  // standby first
  logic [7:0]  pm [4] = '{8'h01, 8'h00, 8'h03, 8'h01};  // interval, then filter on
  logic [15:0] pw [4] = '{16'h0015, 16'h0015, 16'h0007, 16'h0003};
  ect_timer dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .cap_pin_i(cap_pin), .watch_clk_i(wdiv[3]), .irq_o(irq));
  ect_pulse_src src_u (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .width_i(width), .hold_i(hold), .pin_o(cap_pin));
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) wdiv <= wdiv + 4'h1;
  // next random word
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // fall capture from rise capture, clear field and ticks between edges
  function automatic logic [7:0] exp_fall(input logic [1:0] c, input logic [7:0] r, input logic [7:0] k);
    return (c[1] ? 8'h00 : r) + k;
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle, held until ack is sampled
  task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdat <= {24'h00_0000, d};
    // wait for the answer however long it takes; only the watchdog ends a hang
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    rdv = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 8'h00);
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic pulse(input logic [15:0] w);
    @(posedge clk_i);
    width <= w;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
  endtask
  task automatic complete_run();
    $display("checks_done %0d n_errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    wait_clk(20000);
    n_errors++;
    complete_run();
  end
  initial begin : main
    logic [7:0] r;
    logic [7:0] k;
    logic [7:0] div;
    logic [1:0] cclr;
    logic [1:0] cks;
    wait_clk(2);
    rst_i <= 1'b0;
    wr(`ECT_OFF_RISE_CAP, 8'h5A);
    wr(8'h1C, 8'hFF);
    foreach (ra[i]) begin
      rd(ra[i]);
      check(rdv[7:0], rv[i]);
    end
    wr(`ECT_OFF_PORT_MODE, 8'h01);
    wr(`ECT_OFF_IRQ_MASK, 8'h01);
    // captures for each clear mode and clock source
    for (int i = 0; i < 7; i++) begin
      seed = xs(seed);
      cks = (i < 4) ? 2'b10 : (2'(i - 4) ^ 2'b01);
      div = (cks == 2'b10) ? 8'h02 : ((cks == 2'b01) ? 8'h20 : 8'h40);
      k = (i < 4) ? 8'h05 + 8'(seed % 32'h0000_0038) : 8'h02;
      cclr = (i < 4) ? 2'(i) : seed[1:0];
      wr(`ECT_OFF_CONTROL, {4'h0, cclr, cks});
      wait_clk(20);
      // width a whole number of ticks, one more when the rise clears the count
      pulse(16'(div) * 16'(k) + {15'h0000, cclr[1]});
      wait_clk(int'(div) * int'(k) + 30);
      rd(`ECT_OFF_RISE_CAP);
      r = rdv[7:0];
      rd(`ECT_OFF_FALL_CAP);
      check(rdv[7:0], exp_fall(cclr, r, k));
    end
    // interrupt edge select
    for (int e = 0; e < 2; e++) begin
      wr(`ECT_OFF_CONTROL, {3'b000, e[0], 4'b0010});
      wr(`ECT_OFF_IRQ_STATUS, 8'h01);
      pulse(16'h003D);
      wait_clk(30);
      rd(`ECT_OFF_IRQ_STATUS);
      check(rdv[7:0], {7'h00, !e[0]});
      check({7'h00, irq}, {7'h00, !e[0]});
      wait_clk(60);
      rd(`ECT_OFF_IRQ_STATUS);
      check(rdv[7:0], 8'h01);
    end
    // pulses that must leave no capture
    for (int j = 0; j < 4; j++) begin
      wr(`ECT_OFF_CLOCK_STOP, cs[j]);
      wr(`ECT_OFF_PORT_MODE, pm[j]);
      wait_clk(30);
      wr(`ECT_OFF_IRQ_STATUS, 8'h01);
      rd(`ECT_OFF_RISE_CAP);
      r = rdv[7:0];
      pulse(pw[j]);
      wait_clk(60);
      rd(`ECT_OFF_RISE_CAP);
      check(rdv[7:0], r);
      rd(`ECT_OFF_IRQ_STATUS);
      check(rdv[7:0], 8'h00);
      wr(`ECT_OFF_CLOCK_STOP, 8'hFF);
      wr(`ECT_OFF_PORT_MODE, 8'h01);
    end
    // overflow with the pin held high, capture then interval mode
    hold <= 1'b1;
    for (int p = 1; p >= 0; p--) begin
      wr(`ECT_OFF_PORT_MODE, {7'h00, p[0]});
      wr(`ECT_OFF_CONTROL, 8'h22);
      wait_clk(20);
      rd(`ECT_OFF_CONTROL);
      wr(`ECT_OFF_CONTROL, 8'h22);
      wr(`ECT_OFF_IRQ_STATUS, 8'h01);
      wait_clk(600);
      rd(`ECT_OFF_CONTROL);
      check({6'h00, rdv[7:6]}, {6'h00, p[0], !p[0]});
      rd(`ECT_OFF_IRQ_STATUS);
      check(rdv[7:0], 8'h01);
      check({7'h00, irq}, 8'h01);
    end
    hold <= 1'b0;
    wr(`ECT_OFF_CONTROL, 8'hC0);
    rd(`ECT_OFF_CONTROL);
    check(rdv[7:0], 8'h40);
    wr(`ECT_OFF_CONTROL, 8'h00);
    rd(`ECT_OFF_CONTROL);
    check(rdv[7:0], 8'h00);
    complete_run();
  end
endmodule // tb
bind ect_timer ect_timer_sva chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .cap_pin_i(cap_pin_i), .watch_clk_i(watch_clk_i), .irq_o(irq_o));
`default_nettype wire
